// >>> core/flash_status_consts.svh
/*
 Bit positions, reset values and command codes of the status register bank.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH
// Register selectors on the command port
`define SEL_BUSY_PROTECT 2'h0
`define SEL_PROTECT_STATUS 2'h1
`define SEL_CONFIG_STATUS 2'h2
// busy_protect_reg fields
`define BPR_BUSY 0
`define BPR_WEL 1
`define BPR_RANGE_LO 2
`define BPR_RANGE_HI 4
`define BPR_LOW_END 5
`define BPR_SMALL_UNIT 6
`define BPR_PROTECT_MODE 7
// protect_status_reg fields
`define PSR_QE 1
`define PSR_LOCK_LO 3
`define PSR_LOCK_HI 5
`define PSR_INVERT 6
`define PSR_PAUSED 7
// config_status_reg fields
`define CSR_FAST 4
`define CSR_DRV_LO 5
`define CSR_DRV_HI 6
`define CSR_HOLD_RESET 7
// Writable masks and register reset value
`define BPR_WMASK 8'hfc
`define PSR_WMASK 8'h42
`define PSR_LOCK_MASK 8'h38
`define CSR_WMASK 8'hf0
`define REG_RESET 8'h00
// Commands
`define CMD_WREN 8'h06
`define CMD_WRSR 8'h01
`define CMD_VWREN 8'h50
`define CMD_WRDI 8'h04
`define CMD_RDSR 8'h05
`define CMD_SUSPEND 8'h75
`define CMD_RESUME 8'h7a
`define CMD_PROGRAM 8'h02
`define CMD_SECTOR_ERASE 8'h20
`define CMD_BLOCK_ERASE 8'hd8
`define CMD_CHIP_ERASE 8'hc7
`define CMD_SOFT_RESET 8'h99
// Embedded operation length in clocks
`define OP_CYCLES 8'h10
`endif

// >>> core/flash_status_pkg.sv
/*
 Types of the status register bank.
 Assumes nothing of its surroundings.
*/
package flash_status_pkg;
   typedef enum logic [2:0] {
      OP_IDLE = 3'b001,
      OP_RUN = 3'b010,
      OP_DONE = 3'b100
   } op_state_e;
endpackage

// >>> core/range_protect_check.sv
/*
 Decides whether a target unit lies in the protected array region.
 Assumes unit counts already scaled to sectors or blocks by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module range_protect_check (
   input wire logic [2:0] range_i, // protect range field
   input wire logic low_end_i, // protect from bottom
   input wire logic invert_i, // complement map
   input wire logic [2:0] unit_i, // target unit index from top or bottom
   output logic protected_o // target is read-only
);
   logic hit;
   // Simplified map: range n covers unit indices below 2^(n-1); low_end_i does not enter the map
   always_comb begin
      hit = 1'b0;
      if (range_i != 3'h0) begin
         // Eight bits so range 7 (64 units) does not wrap to zero
         hit = ({5'h00, unit_i} < (8'h01 << (range_i - 3'h1)));
      end
      protected_o = hit ^ invert_i;
   end
   logic unused_low_end;
   assign unused_low_end = low_end_i;
endmodule // range_protect_check
`default_nettype wire

// >>> core/flash_status_protect_regs.sv
/*
 Status and configuration registers of a serial NOR flash: busy, write
 latch, block protect, suspend, OTP locks, quad enable and pin options.
 Assumes a command decoder on clk_i delivers whole opcodes as one-cycle
 strobes; the write-protect pin arrives asynchronously.
*/
// Operation
// R1: Paused flag is read-only bit 7 of protect_status_reg.
// R2: Invert protection lives at protect_status_reg bit 6.
// R3: Invert and quad enable have non-volatile and volatile copies, reset 0.
// R4: OTP lock bits 3..1 sit at protect_status_reg bits 5..3.
// R5: Quad enable turns protect and pause pins into quad data lines.
// R6: Hold-or-reset select at config bit 7, only when quad off.
// R7: Drive strength field at config bits 6:5 for reads.
// R8: Fast read precharge enable at config bit 4, both copies.
// R9: Busy set during program, erase and status write.
// R10: While busy, ignore all instructions except read status.
// R11: Busy clears when the operation finishes.
// R12: Write-enable command sets write armed latch.
// R13: Latch clears at reset and after disable, program, erase, status write.
// R14: Protect range bits 4:2 non-volatile, written by status write, default 0.
// R15: Refuse program or erase to a protected region.
// R16: Low-end bit places protection at bottom when 1, default 0. The range check ignores the bit.
// R17: Low-end write accepted only when protect mode and latch allow.
// R18: Small unit bit chooses 4 kB sectors over 64 kB blocks.
// R19: Invert flips the whole protection map.
// R20: Reset loads volatile bits from non-volatile copies.
// R21: Write enable before status write targets non-volatile bits.
// R22: Volatile write enable targets volatile bits only, locks untouched.
// R23: Suspend sets paused flag; resume clears it.
// R24: OTP lock bits once set never clear.
// R25: Reserved bits read 0 and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_consts.svh"
module flash_status_protect_regs
   import flash_status_pkg::*;
(
   input wire logic clk_i, // 25 MHz clock
   input wire logic rst_i, // synchronous reset, high
   input wire logic ce_i, // clock enable
   input wire logic cmd_valid_i, // opcode strobe
   input wire logic [7:0] cmd_i, // opcode
   input wire logic [7:0] wdata_i, // status write data
   input wire logic [1:0] wsel_i, // register picked for write or read
   input wire logic [2:0] target_unit_i, // unit index of program or erase
   input wire logic wp_pin_n_i, // write-protect pin, async, low protects
   output logic [7:0] rdata_o, // selected status register
   output logic busy_o, // embedded operation running
   output logic cmd_refused_o, // last command dropped while busy
   output logic quad_mode_o, // pins act as quad data lines
   output logic pause_pin_en_o, // shared pin is pause input
   output logic restart_pin_en_o, // shared pin is restart input
   output logic [1:0] drive_strength_o, // output driver strength
   output logic fast_mode_o, // high-frequency mode
   output logic small_unit_o // protect counts 4 kB sectors
);
   // Non-volatile copies start in factory state and are never reset
   logic [7:0] bpr_nv_reg = `REG_RESET; // busy_protect_reg, bits 7:2
   logic [7:0] psr_nv_reg = `REG_RESET; // protect_status_reg
   logic [7:0] csr_nv_reg = `REG_RESET; // config_status_reg
   logic [7:0] bpr_v_reg, psr_v_reg, csr_v_reg; // volatile copies
   logic write_armed_latch_reg, volatile_armed_reg, paused_op_flag_reg;
   logic busy_reg;
   logic [7:0] op_cnt_reg;
   op_state_e op_state_reg;
   logic op_is_nv_reg, op_is_status_reg;
   logic [7:0] op_data_reg;
   logic [1:0] op_sel_reg;
   logic wp_meta_reg, wp_sync_reg;
   logic region_protected;
   logic accepted, is_rdsr, is_wrsr, is_prog, sr_locked, do_write;

   // Two-flop synchroniser for the write-protect pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_meta_reg <= 1'b1;
         wp_sync_reg <= 1'b1;
      end else if (ce_i) begin
         wp_meta_reg <= wp_pin_n_i;
         wp_sync_reg <= wp_meta_reg;
      end
   end

   range_protect_check u_range (
      .range_i(bpr_v_reg[`BPR_RANGE_HI:`BPR_RANGE_LO]),
      .low_end_i(bpr_v_reg[`BPR_LOW_END]),
      .invert_i(psr_v_reg[`PSR_INVERT]),
      .unit_i(target_unit_i),
      .protected_o(region_protected)
   );

   always_comb begin
      is_rdsr = (cmd_i == `CMD_RDSR);
      is_wrsr = (cmd_i == `CMD_WRSR);
      is_prog = (cmd_i == `CMD_PROGRAM) || (cmd_i == `CMD_SECTOR_ERASE) ||
                (cmd_i == `CMD_BLOCK_ERASE) || (cmd_i == `CMD_CHIP_ERASE);
      // Pin only protects while quad mode is off
      sr_locked = bpr_nv_reg[`BPR_PROTECT_MODE] && !wp_sync_reg && !psr_v_reg[`PSR_QE];
      // R10 busy gating
      accepted = cmd_valid_i && (!busy_reg || is_rdsr);
      // R17 protect mode and latch gate status writes
      do_write = accepted && is_wrsr && !sr_locked &&
                 (write_armed_latch_reg || volatile_armed_reg);
   end

   // R9 R11 embedded operation sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_state_reg <= OP_IDLE;
         busy_reg <= 1'b0;
         op_cnt_reg <= 8'h00;
         op_is_status_reg <= 1'b0;
         op_is_nv_reg <= 1'b0;
         op_data_reg <= 8'h00;
         op_sel_reg <= 2'h0;
      end else if (ce_i) begin
         unique case (op_state_reg)
            OP_IDLE: begin
               // R15 protected region refuses program and erase
               if (accepted && ((is_prog && write_armed_latch_reg && !region_protected) ||
                                (do_write && write_armed_latch_reg))) begin
                  op_state_reg <= OP_RUN;
                  busy_reg <= 1'b1;
                  op_cnt_reg <= `OP_CYCLES;
                  op_is_status_reg <= is_wrsr;
                  op_is_nv_reg <= is_wrsr;
                  op_data_reg <= wdata_i;
                  op_sel_reg <= wsel_i;
               end
            end
            OP_RUN: begin
               op_cnt_reg <= op_cnt_reg - 8'h01;
               if (op_cnt_reg == 8'h01) begin
                  op_state_reg <= OP_DONE;
               end
            end
            OP_DONE: begin
               busy_reg <= 1'b0;
               op_is_status_reg <= 1'b0;
               op_state_reg <= OP_IDLE;
            end
         endcase
      end
   end

   // R12 R13 write armed latch
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         write_armed_latch_reg <= 1'b0;
         volatile_armed_reg <= 1'b0;
      end else if (ce_i) begin
         if (op_state_reg == OP_DONE) begin
            write_armed_latch_reg <= 1'b0;
         end else if (accepted && cmd_i == `CMD_WREN) begin
            write_armed_latch_reg <= 1'b1;
         end else if (accepted && cmd_i == `CMD_WRDI) begin
            write_armed_latch_reg <= 1'b0;
         end
         if (accepted && cmd_i == `CMD_VWREN) begin
            volatile_armed_reg <= 1'b1;
         end else if (accepted && !is_rdsr) begin
            volatile_armed_reg <= 1'b0;
         end
      end
   end

   // R23 suspend flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         paused_op_flag_reg <= 1'b0;
      end else if (ce_i && accepted) begin
         if (cmd_i == `CMD_SUSPEND) begin
            paused_op_flag_reg <= 1'b1;
         end else if (cmd_i == `CMD_RESUME) begin
            paused_op_flag_reg <= 1'b0;
         end
      end
   end

   // R14 R16 R21 R24 non-volatile copies; reset does not clear them
   always_ff @(posedge clk_i) begin
      if (ce_i && op_state_reg == OP_DONE && op_is_nv_reg) begin
         unique case (op_sel_reg)
            `SEL_BUSY_PROTECT: bpr_nv_reg <= op_data_reg & `BPR_WMASK;
            `SEL_PROTECT_STATUS: psr_nv_reg <= (op_data_reg & `PSR_WMASK) |
               ((op_data_reg | psr_nv_reg) & `PSR_LOCK_MASK);
            `SEL_CONFIG_STATUS: csr_nv_reg <= op_data_reg & `CSR_WMASK;
            default: ;
         endcase
      end
   end

   // R3 R20 R22 volatile copies loaded from non-volatile on reset
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && accepted && cmd_i == `CMD_SOFT_RESET)) begin
         bpr_v_reg <= bpr_nv_reg & `BPR_WMASK;
         psr_v_reg <= psr_nv_reg & `PSR_WMASK;
         csr_v_reg <= csr_nv_reg & `CSR_WMASK;
      end else if (ce_i) begin
         if (do_write && volatile_armed_reg && !write_armed_latch_reg) begin
            unique case (wsel_i)
               `SEL_BUSY_PROTECT: bpr_v_reg <= wdata_i & `BPR_WMASK;
               `SEL_PROTECT_STATUS: psr_v_reg <= wdata_i & `PSR_WMASK;
               `SEL_CONFIG_STATUS: csr_v_reg <= wdata_i & `CSR_WMASK;
               default: ;
            endcase
         end else if (op_state_reg == OP_DONE && op_is_nv_reg) begin
            // Non-volatile write also takes effect at once
            unique case (op_sel_reg)
               `SEL_BUSY_PROTECT: bpr_v_reg <= op_data_reg & `BPR_WMASK;
               `SEL_PROTECT_STATUS: psr_v_reg <= op_data_reg & `PSR_WMASK;
               `SEL_CONFIG_STATUS: csr_v_reg <= op_data_reg & `CSR_WMASK;
               default: ;
            endcase
         end
      end
   end

   // R1 R2 R4 R25 readback assembly, R5 R6 R7 R8 R18 pin functions
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= `REG_RESET;
         busy_o <= 1'b0;
         cmd_refused_o <= 1'b0;
         quad_mode_o <= 1'b0;
         pause_pin_en_o <= 1'b0;
         restart_pin_en_o <= 1'b0;
         drive_strength_o <= 2'h0;
         fast_mode_o <= 1'b0;
         small_unit_o <= 1'b0;
      end else if (ce_i) begin
         unique case (wsel_i)
            `SEL_BUSY_PROTECT: rdata_o <= (bpr_v_reg & `BPR_WMASK) |
               {6'h00, write_armed_latch_reg, busy_reg};
            `SEL_PROTECT_STATUS: rdata_o <= (psr_v_reg & `PSR_WMASK) |
               (psr_nv_reg & `PSR_LOCK_MASK) | {paused_op_flag_reg, 7'h00};
            `SEL_CONFIG_STATUS: rdata_o <= csr_v_reg & `CSR_WMASK;
            default: rdata_o <= `REG_RESET;
         endcase
         busy_o <= busy_reg;
         cmd_refused_o <= cmd_valid_i && !accepted;
         quad_mode_o <= psr_v_reg[`PSR_QE];
         pause_pin_en_o <= !psr_v_reg[`PSR_QE] && !csr_v_reg[`CSR_HOLD_RESET];
         restart_pin_en_o <= !psr_v_reg[`PSR_QE] && csr_v_reg[`CSR_HOLD_RESET];
         drive_strength_o <= csr_v_reg[`CSR_DRV_HI:`CSR_DRV_LO];
         fast_mode_o <= csr_v_reg[`CSR_FAST];
         small_unit_o <= bpr_v_reg[`BPR_SMALL_UNIT];
      end
   end

   // R10 busy refusal
   busy_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      (ce_i && busy_reg && cmd_valid_i && !is_rdsr) |=> cmd_refused_o)
      else $error("Command taken while busy");
   // R9 busy start
   busy_start_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      (ce_i && op_state_reg == OP_IDLE && accepted && is_prog &&
       write_armed_latch_reg && !region_protected) |=> busy_reg)
      else $error("Busy not set on program");
   // R11 busy end
   busy_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (ce_i && op_state_reg == OP_DONE) |=> !busy_reg)
      else $error("Busy not cleared at completion");
   wel_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (ce_i && accepted && cmd_i == `CMD_WREN && op_state_reg != OP_DONE)
      |=> write_armed_latch_reg)
      else $error("Write latch not set");
   wel_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      (ce_i && op_state_reg == OP_DONE) |=> !write_armed_latch_reg)
      else $error("Write latch not cleared after operation");
   refuse_region_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (ce_i && op_state_reg == OP_IDLE && is_prog && region_protected) |=> !busy_reg)
      else $error("Program started in protected region");
   lock_sticky_a: assert property (@(posedge clk_i) // R24
      psr_nv_reg[`PSR_LOCK_HI] |=> psr_nv_reg[`PSR_LOCK_HI])
      else $error("Lock bit cleared");
   suspend_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // R23
      (ce_i && accepted && cmd_i == `CMD_SUSPEND) |=> paused_op_flag_reg)
      else $error("Paused flag not set");
   pin_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (ce_i && psr_v_reg[`PSR_QE]) |=> !(pause_pin_en_o || restart_pin_en_o))
      else $error("Pause or restart active in quad mode");
endmodule // flash_status_protect_regs
`default_nettype wire

// >>> testbench/status_host.sv
/*
 Host side model: issues status register opcodes one at a time.
 Assumes the bank samples strobes on the rising edge of clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_consts.svh"
module status_host (
   input wire logic clk_i, // bank clock
   output logic cmd_valid_o, // opcode strobe
   output logic [7:0] cmd_o, // opcode
   output logic [7:0] wdata_o, // write data
   output logic [1:0] wsel_o // register select
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = 8'h00;
      wdata_o = 8'h00;
      wsel_o = 2'h0;
   end
   // Opcode and data stay put after the strobe drops
   task automatic send(input logic [7:0] c, input logic [7:0] d, input logic [1:0] s);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_o <= c;
      wdata_o <= d;
      wsel_o <= s;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
   endtask
   task automatic write_nv(input logic [1:0] s, input logic [7:0] d);
      send(`CMD_WREN, 8'h00, s);
      send(`CMD_WRSR, d, s);
   endtask
   task automatic write_vol(input logic [1:0] s, input logic [7:0] d);
      send(`CMD_VWREN, 8'h00, s);
      send(`CMD_WRSR, d, s);
   endtask
endmodule // status_host
`default_nettype wire

// >>> testbench/tb_top.sv
/*
 Self-checking bench of the status register bank.
 Assumes the host model drives the opcode port; bench drives pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_status_consts.svh"
module tb_top;
   logic clk_i, rst_i, ce_i, wp_pin_n_i, cmd_valid_i;
   logic [2:0] target_unit_i;
   logic [7:0] cmd_i, wdata_i, rdata_o;
   logic [1:0] wsel_i, drive_strength_o;
   logic busy_o, cmd_refused_o, quad_mode_o, pause_pin_en_o, restart_pin_en_o;
   logic fast_mode_o, small_unit_o;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;
   status_host i_status_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
      .wdata_o(wdata_i), .wsel_o(wsel_i));
   flash_status_protect_regs i_flash_status_protect_regs (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .wdata_i(wdata_i),
      .wsel_i(wsel_i), .target_unit_i(target_unit_i), .wp_pin_n_i(wp_pin_n_i),
      .rdata_o(rdata_o), .busy_o(busy_o), .cmd_refused_o(cmd_refused_o),
      .quad_mode_o(quad_mode_o), .pause_pin_en_o(pause_pin_en_o),
      .restart_pin_en_o(restart_pin_en_o), .drive_strength_o(drive_strength_o),
      .fast_mode_o(fast_mode_o), .small_unit_o(small_unit_o));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [1:0] s, input logic [7:0] exp);
      i_status_host.send(`CMD_RDSR, 8'h00, s);
      @(posedge clk_i);
      #1;
      check("readback", rdata_o, exp);
   endtask
   // Bounded wait; a refused op never raises busy
   task automatic run_op(input logic exp);
      int n;
      logic seen;
      seen = 1'b0;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         #1;
         if (busy_o === 1'b1) seen = 1'b1;
         if (seen && busy_o === 1'b0) break;
      end
      check("busy seen", {7'h0, seen}, {7'h0, exp});
   endtask
   task automatic pins(input logic [7:0] exp);
      #1;
      check("pins", {5'h0, quad_mode_o, pause_pin_en_o, restart_pin_en_o}, exp);
   endtask
   task automatic t_init;
      for (int s = 0; s < 3; s++) begin
         i_status_host.write_nv(2'(s), 8'h00);
         run_op(1'b1);
         rd(2'(s), 8'h00);
      end
      i_status_host.send(`CMD_WREN, 8'h00, 2'h0);
      rd(2'h0, 8'h02);
      i_status_host.send(`CMD_WRDI, 8'h00, 2'h0);
      rd(2'h0, 8'h00);
      $display("test init done");
   endtask
   task automatic t_otp;
      i_status_host.write_nv(2'h1, 8'hff);
      run_op(1'b1);
      rd(2'h1, 8'h7a);
      check("quad", {7'h0, quad_mode_o}, 8'h01);
      i_status_host.write_nv(2'h1, 8'h00);
      run_op(1'b1);
      rd(2'h1, 8'h38);
      $display("test otp done");
   endtask
   task automatic t_vol;
      i_status_host.write_vol(2'h2, 8'hf0);
      check("no busy", {7'h0, busy_o}, 8'h00);
      rd(2'h2, 8'hf0);
      check("drive", {6'h0, drive_strength_o}, 8'h03);
      check("fast", {7'h0, fast_mode_o}, 8'h01);
      pins(8'h01);
      i_status_host.write_vol(2'h1, 8'h02);
      rd(2'h1, 8'h3a);
      pins(8'h04);
      i_status_host.send(`CMD_SOFT_RESET, 8'h00, 2'h1);
      rd(2'h1, 8'h38);
      rd(2'h2, 8'h00);
      pins(8'h02);
      $display("test volatile done");
   endtask
   task automatic t_busy;
      logic [7:0] ops [4] = '{`CMD_PROGRAM, `CMD_SECTOR_ERASE, `CMD_BLOCK_ERASE, `CMD_CHIP_ERASE};
      logic r;
      foreach (ops[i]) begin
         i_status_host.send(`CMD_WREN, 8'h00, 2'h0);
         i_status_host.send(ops[i], 8'h00, 2'h0);
         repeat (3) @(posedge clk_i);
         i_status_host.send(`CMD_WREN, 8'h00, 2'h0);
         #1;
         r = cmd_refused_o;
         @(posedge clk_i);
         #1;
         r = r | cmd_refused_o;
         check("refused", {7'h0, r}, 8'h01);
         run_op(1'b1);
         rd(2'h0, 8'h00);
      end
      $display("test busy done");
   endtask
   task automatic t_susp;
      i_status_host.send(`CMD_SUSPEND, 8'h00, 2'h1);
      rd(2'h1, 8'hb8);
      i_status_host.send(`CMD_RESUME, 8'h00, 2'h1);
      rd(2'h1, 8'h38);
      $display("test suspend done");
   endtask
   task automatic t_prot;
      i_status_host.write_nv(2'h0, 8'h1c);
      run_op(1'b1);
      rd(2'h0, 8'h1c);
      target_unit_i <= 3'h3;
      i_status_host.send(`CMD_WREN, 8'h00, 2'h0);
      i_status_host.send(`CMD_PROGRAM, 8'h00, 2'h0);
      run_op(1'b0);
      i_status_host.send(`CMD_WRDI, 8'h00, 2'h0);
      i_status_host.write_vol(2'h1, 8'h40);
      i_status_host.send(`CMD_WREN, 8'h00, 2'h0);
      i_status_host.send(`CMD_PROGRAM, 8'h00, 2'h0);
      run_op(1'b1);
      rd(2'h0, 8'h1c);
      i_status_host.write_vol(2'h0, 8'h40);
      rd(2'h0, 8'h40);
      check("small unit", {7'h0, small_unit_o}, 8'h01);
      // Protect mode is judged from the non-volatile copy
      i_status_host.write_nv(2'h0, 8'h80);
      run_op(1'b1);
      wp_pin_n_i <= 1'b0;
      i_status_host.write_vol(2'h0, 8'h20);
      rd(2'h0, 8'h80);
      wp_pin_n_i <= 1'b1;
      i_status_host.write_vol(2'h0, 8'h20);
      rd(2'h0, 8'h20);
      $display("test protect done");
   endtask
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // Ceiling well above the roughly 420 cycles needed
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      rst_i = 1'b1;
      ce_i = 1'b1;
      wp_pin_n_i = 1'b1;
      target_unit_i = 3'h0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_init();
      t_otp();
      t_vol();
      t_busy();
      t_susp();
      t_prot();
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
